// ---- acr_pkg.sv ----
// register map, field positions and decode codes for the amplifier configuration block
package acr_pkg;
	localparam logic [7:0] OFS_CTRL0    = 8'ha3;
	localparam logic [7:0] OFS_CTRL1    = 8'ha4;
	localparam logic [7:0] OFS_CTRL2    = 8'ha5;
	localparam logic [7:0] OFS_CTRL3    = 8'ha6;
	localparam logic [7:0] OFS_OVR_CTRL = 8'ha7;
	localparam logic [7:0] OFS_OVR_SRC  = 8'ha9;
	localparam logic [7:0] RST_REG      = 8'h00;
	// control 0 fields
	localparam int BIT_ENABLE   = 7;
	localparam int BIT_PUMP     = 5;
	localparam int BIT_UNITY    = 3;
	localparam int LSB_SWMODE   = 0;
	localparam logic [7:0] MSK_CTRL0 = 8'hab;
	// control 1 fields
	localparam int LSB_GAIN     = 4;
	localparam int BIT_LADDER   = 3;
	localparam int LSB_NPIN     = 0;
	localparam logic [7:0] MSK_CTRL1 = 8'h7f;
	// control 2 fields
	localparam int LSB_NCH      = 4;
	localparam int LSB_PCH      = 0;
	localparam logic [7:0] MSK_CTRL2 = 8'h77;
	// control 3 fields
	localparam int LSB_FB       = 6;
	localparam int LSB_PPIN     = 0;
	localparam logic [7:0] MSK_CTRL3 = 8'hc3;
	// override control and override source fields
	localparam int BIT_OVR_EN   = 7;
	localparam int LSB_HIGH_CFG = 4;
	localparam int BIT_OVR_POL  = 3;
	localparam int LSB_LOW_CFG  = 0;
	localparam logic [7:0] MSK_OVR_SRC = 8'h1f;
	localparam logic [4:0] OVR_SRC_MAX = 5'h15;
	// software output mode codes
	localparam logic [1:0] SW_NORMAL = 2'h0;
	localparam logic [1:0] SW_LOW    = 2'h1;
	localparam logic [1:0] SW_HIGH   = 2'h2;
	// override configuration codes
	localparam logic [2:0] HW_USER   = 3'h0;
	localparam logic [2:0] HW_UNITY  = 3'h4;
	localparam logic [2:0] HW_RAIL   = 3'h7;
	// inverting channel codes
	localparam logic [2:0] NCH_NONE  = 3'h0;
	localparam logic [2:0] NCH_LAD   = 3'h1;
	localparam logic [2:0] NCH_PIN   = 3'h2;
	localparam logic [2:0] NCH_CNV1  = 3'h4;
	localparam logic [2:0] NCH_CNV2  = 3'h5;
	// noninverting channel codes
	localparam logic [2:0] PCH_VSS   = 3'h0;
	localparam logic [2:0] PCH_LAD   = 3'h1;
	localparam logic [2:0] PCH_PIN   = 3'h2;
	localparam logic [2:0] PCH_HALF  = 3'h3;
	localparam logic [2:0] PCH_CNV1  = 3'h4;
	localparam logic [2:0] PCH_CNV2  = 3'h5;
	// feedback codes
	localparam logic [1:0] FB_NONE   = 2'h0;
	localparam logic [1:0] FB_VDD    = 2'h1;
	localparam logic [1:0] FB_OUTPIN = 2'h2;
	// inverting pin select: supply code and highest pin code
	localparam logic [2:0] NPIN_VSS  = 3'h7;
	localparam logic [2:0] NPIN_MAX  = 3'h3;
endpackage : acr_pkg

// ---- acr_regs.sv ----
// amplifier configuration registers, hardware override and analog switch decode
//
// Behaviour
// - enable bit 7 of control 0; clear switches amplifier off entirely.
// - charge pump bit 5 of control 0 turns the pump on or off.
// - unity gain bit 3 ties output to inverting input, frees inverting pins.
// - software output mode: 10 high rail, 01 low rail, 00 normal, 11 reserved.
// - three-bit gain field picks one of eight ladder tap pairs.
// - ladder enable bit 3 of control 1 connects ladder; clear keeps it off.
// - inverting pin select: 000-011 pins 0-3, 111 low supply, rest reserved.
// - inverting channel: none, ladder, pin, converter 1, converter 2.
// - noninverting channel: low supply, ladder, pin, half supply, two converters.
// - feedback field bits 7:6 of control 3: none, high supply, output pin.
// - noninverting pin select maps codes 0-3 onto pins 0-3.
// - override enable bit 7 takes mode from high or low config fields.
// - high config: 111 high rail, 100 unity gain, 000 user feedback.
// - override control register resets to zero, all bits read and write.
// - converter channel pin choice overrides both pin select fields.
// - output routed to converter keeps output pin away from general use.
// - low config: 111 low rail, 100 unity gain, 000 user feedback.
// - polarity bit 3 inverts the override input when set.
// - five-bit override source select; codes above 10101 reserved.
//
// Timing
// every output is a flop, fed by the registers except outpin_gpio_block, so a write shows one edge later
// read data stands for one cycle after the read strobe and is zero otherwise
// override sources pass two flops each before the select mux, then the output flop
// changing the source select acts at once on the already synchronised levels
//
// Limitations
// reserved codes are stored as written and close no switch
// the converter pin override reaches inverting pins 0 to 3 only, never the low supply
// the offset trim register is not kept here; its address reads zero
// pin and channel switches open whenever the amplifier is disabled
// ninv_free follows the unity choice even while disabled
// a write and a read may follow back to back with no gap
`timescale 1ns/1ps
`default_nettype none
module acr_regs (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic [31:0] ovr_sources,
	input  wire logic       conv_route,
	input  wire logic       conv_sel_valid,
	input  wire logic [1:0] conv_ppin,
	input  wire logic [1:0] conv_npin,
	output logic            amp_on,
	output logic            pump_on,
	output logic            unity_fb,
	output logic            rail_high,
	output logic            rail_low,
	output logic            ladder_on,
	output logic      [7:0] ladder_tap,
	output logic      [3:0] npin_on,
	output logic            nvss_on,
	output logic            ninv_free,
	output logic      [4:0] nch_on,
	output logic      [5:0] pch_on,
	output logic      [3:0] ppin_on,
	output logic      [1:0] fb_on,
	output logic            outpin_gpio_block
);
	logic [7:0] ctrl0_r;
	logic [7:0] ctrl1_r;
	logic [7:0] ctrl2_r;
	logic [7:0] ctrl3_r;
	logic [7:0] ovr_ctrl_r;
	logic [7:0] ovr_src_r;
	logic [7:0] rdata_nxt;
	logic [31:0] src_meta_r;
	logic [31:0] src_sync_r;
	logic       src_pick;
	logic       ovr_level;
	logic [2:0] hw_cfg;
	logic       use_unity;
	logic       use_high;
	logic       use_low;
	logic [1:0] ppin_sel;
	logic [2:0] npin_sel;
	logic [2:0] gain;

	// one-hot pin decode, used for both pin select fields
	function automatic logic [3:0] pin_hot(input logic [1:0] code);
		pin_hot = 4'h1 << code;
	endfunction : pin_hot

	// register writes; unwritable bits are masked so they read back as zero
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl0_r    <= acr_pkg::RST_REG;
			ctrl1_r    <= acr_pkg::RST_REG;
			ctrl2_r    <= acr_pkg::RST_REG;
			ctrl3_r    <= acr_pkg::RST_REG;
			ovr_ctrl_r <= acr_pkg::RST_REG;
			ovr_src_r  <= acr_pkg::RST_REG;
		end else if (wr) begin
			unique case (addr)
				acr_pkg::OFS_CTRL0:    ctrl0_r    <= wdata & acr_pkg::MSK_CTRL0;
				acr_pkg::OFS_CTRL1:    ctrl1_r    <= wdata & acr_pkg::MSK_CTRL1;
				acr_pkg::OFS_CTRL2:    ctrl2_r    <= wdata & acr_pkg::MSK_CTRL2;
				acr_pkg::OFS_CTRL3:    ctrl3_r    <= wdata & acr_pkg::MSK_CTRL3;
				acr_pkg::OFS_OVR_CTRL: ovr_ctrl_r <= wdata;
				acr_pkg::OFS_OVR_SRC:  ovr_src_r  <= wdata & acr_pkg::MSK_OVR_SRC;
				default: ;
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		unique case (addr)
			acr_pkg::OFS_CTRL0:    rdata_nxt = ctrl0_r;
			acr_pkg::OFS_CTRL1:    rdata_nxt = ctrl1_r;
			acr_pkg::OFS_CTRL2:    rdata_nxt = ctrl2_r;
			acr_pkg::OFS_CTRL3:    rdata_nxt = ctrl3_r;
			acr_pkg::OFS_OVR_CTRL: rdata_nxt = ovr_ctrl_r;
			acr_pkg::OFS_OVR_SRC:  rdata_nxt = ovr_src_r;
			default:               rdata_nxt = 8'h00;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd ? rdata_nxt : 8'h00;
		end
	end

	// override sources may come from other clock trees; each one gets its own
	// first stage, costing 32 flops but keeping the select mux off metastable levels
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			src_meta_r <= 32'h0000_0000;
		end else begin
			src_meta_r <= ovr_sources;
		end
	end

	// second stage; nothing but this flop reads the first stage
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			src_sync_r <= 32'h0000_0000;
		end else begin
			src_sync_r <= src_meta_r;
		end
	end

	// source pick; reserved source codes select nothing and hold src_pick low, so the polarity bit alone sets the level
	always_comb begin
		src_pick = 1'b0;
		if (ovr_src_r[4:0] <= acr_pkg::OVR_SRC_MAX) begin
			src_pick = src_sync_r[ovr_src_r[4:0]];
		end
	end

	// mode selection: override fields or software bits
	always_comb begin
		ovr_level = src_pick ^ ovr_ctrl_r[acr_pkg::BIT_OVR_POL];
		hw_cfg    = ovr_level ? ovr_ctrl_r[acr_pkg::LSB_HIGH_CFG +: 3]
		                      : ovr_ctrl_r[acr_pkg::LSB_LOW_CFG +: 3];
		if (ovr_ctrl_r[acr_pkg::BIT_OVR_EN]) begin
			// reserved override codes fall back to user feedback
			use_unity = (hw_cfg == acr_pkg::HW_UNITY);
			use_high  = (hw_cfg == acr_pkg::HW_RAIL) && ovr_level;
			use_low   = (hw_cfg == acr_pkg::HW_RAIL) && !ovr_level;
		end else begin
			use_unity = ctrl0_r[acr_pkg::BIT_UNITY];
			use_high  = ctrl0_r[acr_pkg::LSB_SWMODE +: 2] == acr_pkg::SW_HIGH;
			use_low   = ctrl0_r[acr_pkg::LSB_SWMODE +: 2] == acr_pkg::SW_LOW;
		end
	end

	// pin choice: converter channel selection wins while routed to the converter with conv_sel_valid high
	always_comb begin
		gain = ctrl1_r[acr_pkg::LSB_GAIN +: 3];
		if (conv_route && conv_sel_valid) begin
			ppin_sel = conv_ppin;
			npin_sel = {1'b0, conv_npin};
		end else begin
			ppin_sel = ctrl3_r[acr_pkg::LSB_PPIN +: 2];
			npin_sel = ctrl1_r[acr_pkg::LSB_NPIN +: 3];
		end
	end

	// enable; every output below except ninv_free and outpin_gpio_block is gated by it so a disabled amplifier is quiet
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			amp_on <= 1'b0;
		end else begin
			amp_on <= ctrl0_r[acr_pkg::BIT_ENABLE];
		end
	end

	// charge pump; held off while disabled so the low power state draws nothing
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pump_on <= 1'b0;
		end else begin
			pump_on <= ctrl0_r[acr_pkg::BIT_ENABLE] & ctrl0_r[acr_pkg::BIT_PUMP];
		end
	end

	// unity feedback switch from output to inverting input
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			unity_fb <= 1'b0;
		end else begin
			unity_fb <= ctrl0_r[acr_pkg::BIT_ENABLE] & use_unity;
		end
	end

	// rail drive; the two decodes are exclusive so both rails are never driven
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rail_high <= 1'b0;
			rail_low  <= 1'b0;
		end else begin
			rail_high <= ctrl0_r[acr_pkg::BIT_ENABLE] & use_high;
			rail_low  <= ctrl0_r[acr_pkg::BIT_ENABLE] & use_low;
		end
	end

	// inverting pins freed for general use; not gated by enable, so software
	// may hand the pins over before the amplifier is switched on
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ninv_free <= 1'b0;
		end else begin
			ninv_free <= use_unity;
		end
	end

	// output pin withheld from general use while the output feeds the converter
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			outpin_gpio_block <= 1'b0;
		end else begin
			outpin_gpio_block <= conv_route;
		end
	end

	// ladder connection switch
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ladder_on <= 1'b0;
		end else begin
			ladder_on <= ctrl0_r[acr_pkg::BIT_ENABLE] & ctrl1_r[acr_pkg::BIT_LADDER];
		end
	end

	// ladder tap: one-hot only with the ladder connected
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ladder_tap <= 8'h00;
		end else begin
			ladder_tap <= (ctrl0_r[acr_pkg::BIT_ENABLE] & ctrl1_r[acr_pkg::BIT_LADDER])
				? (8'h01 << gain) : 8'h00;
		end
	end

	// inverting side switches; unity gain disconnects the inverting pins
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			npin_on <= 4'h0;
			nvss_on <= 1'b0;
			nch_on  <= 5'h00;
		end else begin
			npin_on <= 4'h0;
			nvss_on <= 1'b0;
			nch_on  <= 5'h00;
			if (ctrl0_r[acr_pkg::BIT_ENABLE] && !use_unity) begin
				unique case (ctrl2_r[acr_pkg::LSB_NCH +: 3])
					acr_pkg::NCH_NONE: ;
					acr_pkg::NCH_LAD:  nch_on <= 5'h01;
					acr_pkg::NCH_PIN: begin
						nch_on <= 5'h02;
						if (npin_sel <= acr_pkg::NPIN_MAX) begin
							npin_on <= pin_hot(npin_sel[1:0]);
						end else if (npin_sel == acr_pkg::NPIN_VSS) begin
							nvss_on <= 1'b1;
						end
					end
					acr_pkg::NCH_CNV1: nch_on <= 5'h08;
					acr_pkg::NCH_CNV2: nch_on <= 5'h10;
					default: ;
				endcase
			end
		end
	end

	// noninverting side switches
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pch_on  <= 6'h00;
			ppin_on <= 4'h0;
		end else begin
			pch_on  <= 6'h00;
			ppin_on <= 4'h0;
			if (ctrl0_r[acr_pkg::BIT_ENABLE]) begin
				unique case (ctrl2_r[acr_pkg::LSB_PCH +: 3])
					acr_pkg::PCH_VSS:  pch_on <= 6'h01;
					acr_pkg::PCH_LAD:  pch_on <= 6'h02;
					acr_pkg::PCH_PIN: begin
						pch_on  <= 6'h04;
						ppin_on <= pin_hot(ppin_sel);
					end
					acr_pkg::PCH_HALF: pch_on <= 6'h08;
					acr_pkg::PCH_CNV1: pch_on <= 6'h10;
					acr_pkg::PCH_CNV2: pch_on <= 6'h20;
					default: ;
				endcase
			end
		end
	end

	// feedback switches; both closed would tie the high supply to the output pin
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fb_on <= 2'h0;
		end else begin
			fb_on <= 2'h0;
			if (ctrl0_r[acr_pkg::BIT_ENABLE]) begin
				unique case (ctrl3_r[acr_pkg::LSB_FB +: 2])
					acr_pkg::FB_NONE:   ;
					acr_pkg::FB_VDD:    fb_on <= 2'h1;
					acr_pkg::FB_OUTPIN: fb_on <= 2'h2;
					default: ;
				endcase
			end
		end
	end
endmodule : acr_regs
`default_nettype wire

// ---- acr_amp_model.sv ----
// behavioural analog core that flags switch settings which would short its nodes
`timescale 1ns/1ps
`default_nettype none
module acr_amp_model (
	input  wire logic       rail_high,
	input  wire logic       rail_low,
	input  wire logic [3:0] npin_on,
	input  wire logic [3:0] ppin_on,
	input  wire logic [1:0] fb_on,
	output logic            short_err
);
	// two closed switches on one node would tie pins or supplies together
	assign short_err = (rail_high & rail_low) | !$onehot0(npin_on) | !$onehot0(ppin_on)
		| (fb_on == 2'h3);
endmodule : acr_amp_model
`default_nettype wire

// ---- acr_regs_chk.sv ----
// port assertions for the amplifier configuration block
`timescale 1ns/1ps
`default_nettype none
module acr_regs_chk (
	input wire logic       clock,
	input wire logic       resetn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       conv_route,
	input wire logic       amp_on,
	input wire logic       pump_on,
	input wire logic       unity_fb,
	input wire logic       rail_high,
	input wire logic       rail_low,
	input wire logic       ladder_on,
	input wire logic [7:0] ladder_tap,
	input wire logic [3:0] npin_on,
	input wire logic [3:0] ppin_on,
	input wire logic [1:0] fb_on,
	input wire logic       outpin_gpio_block
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	a_off_quiet: assert property (!amp_on |-> !pump_on && !rail_high && !rail_low && !ladder_on)
		else $error("disabled amplifier left a switch closed");
	a_en_write: assert property (wr && addr == 8'ha3 |-> ##2 amp_on == $past(wdata[7], 2))
		else $error("enable output does not follow write");
	a_pump_gate: assert property (pump_on |-> amp_on)
		else $error("pump on while amplifier off");
	a_rail_excl: assert property (!(rail_high && rail_low))
		else $error("both rails driven");
	a_tap_shape: assert property (ladder_on ? $onehot(ladder_tap) : ladder_tap == 8'h00)
		else $error("ladder tap not one-hot or not cleared");
	a_pin_onehot: assert property ($onehot0(npin_on) && $onehot0(ppin_on))
		else $error("more than one input pin switch closed");
	a_fb_legal: assert property (fb_on != 2'h3)
		else $error("both feedback switches closed");
	a_unity_open: assert property (unity_fb |-> npin_on == 4'h0)
		else $error("inverting pin closed in unity mode");
	a_gpio_follow: assert property ($past(resetn) |-> outpin_gpio_block == $past(conv_route))
		else $error("output pin block does not follow routing");
endmodule : acr_regs_chk
bind acr_regs acr_regs_chk u_acr_regs_chk (.clock, .resetn, .addr, .wdata, .wr, .conv_route,
	.amp_on, .pump_on, .unity_fb, .rail_high, .rail_low, .ladder_on, .ladder_tap, .npin_on,
	.ppin_on, .fb_on, .outpin_gpio_block);
`default_nettype wire

// ---- amplifier_config_override_regs_tb.sv ----
// self-checking bench for the amplifier configuration registers
`timescale 1ns/1ps
`default_nettype none
module amplifier_config_override_regs_tb;
	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, ladder_tap;
	logic        wr = 1'b0, rd = 1'b0, conv_route = 1'b0, conv_sel_valid = 1'b0;
	logic [1:0]  conv_ppin = 2'h0, conv_npin = 2'h0, fb_on;
	logic [31:0] ovr_sources = 32'h0;
	logic        amp_on, pump_on, unity_fb, rail_high, rail_low, ladder_on, nvss_on, short_err;
	logic        outpin_gpio_block;
	logic [3:0]  npin_on, ppin_on;
	logic [4:0]  nch_on;
	logic [5:0]  pch_on;
	int          failures = 0, cmp_count = 0;

	acr_regs u_acr_regs (.clock, .resetn, .addr, .wdata, .wr, .rd, .rdata, .ovr_sources,
		.conv_route, .conv_sel_valid, .conv_ppin, .conv_npin, .amp_on, .pump_on,
		.unity_fb, .rail_high, .rail_low, .ladder_on, .ladder_tap, .npin_on, .nvss_on,
		.ninv_free(), .nch_on, .pch_on, .ppin_on, .fb_on, .outpin_gpio_block);
	acr_amp_model u_acr_amp_model (.rail_high, .rail_low, .npin_on, .ppin_on, .fb_on, .short_err);

	// 40 MHz system clock
	always #12.5 clock = ~clock;

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one-cycle write, then two edges so the decoded outputs have landed
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask : wr_reg

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		chk(nm, rdata, exp);
	endtask : rd_chk

	// the override source crosses two sync flops, so allow it several edges
	task automatic src(input logic v);
		@(posedge clock);
		ovr_sources[3] <= v;
		repeat (5) @(posedge clock);
		#1;
	endtask : src

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	// main sequence: registers, decodes, converter routing, hardware override
	initial begin
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		rd_chk("ovr reset", 8'ha7, 8'h00);
		wr_reg(8'ha7, 8'h5a);
		rd_chk("ovr rw", 8'ha7, 8'h5a);
		wr_reg(8'ha8, 8'hff);
		rd_chk("unmapped", 8'ha8, 8'h00);
		wr_reg(8'ha7, 8'h00);
		wr_reg(8'ha3, 8'hff);
		rd_chk("ctrl0 stored", 8'ha3, 8'hab);
		chk("ctrl0 on", {amp_on, pump_on, unity_fb, rail_high, rail_low}, 8'h1c);
		wr_reg(8'ha3, 8'h20);
		chk("ctrl0 off", {amp_on, pump_on}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'ha3, 8'h80 | 8'(i));
			chk("rails", {rail_high, rail_low}, (i == 3) ? 8'h00 : 8'(i));
		end
		for (int g = 0; g < 8; g++) begin
			wr_reg(8'ha4, 8'(g * 16 + 8));
			chk("tap", ladder_tap, 8'(1 << g));
		end
		wr_reg(8'ha4, 8'h70);
		chk("ladder off", ladder_tap | {7'h00, ladder_on}, 8'h00);
		for (int c = 0; c < 8; c++) begin
			wr_reg(8'ha5, 8'(c * 17));
			chk("nch", nch_on, (c inside {1, 2, 4, 5}) ? 8'(1 << (c - 1)) : 8'h00);
			chk("pch", pch_on, (c < 6) ? 8'(1 << c) : 8'h00);
		end
		wr_reg(8'ha5, 8'h22);
		for (int n = 7; n >= 0; n--) begin
			wr_reg(8'ha4, 8'(n));
			chk("npin", {nvss_on, npin_on}, (n < 4) ? 8'(1 << n) : (n == 7) ? 8'h10 : 8'h00);
		end
		for (int f = 0; f < 4; f++) begin
			wr_reg(8'ha6, 8'(f * 65));
			chk("fb", fb_on, (f == 3) ? 8'h00 : 8'(f));
			chk("ppin", ppin_on, 8'(1 << f));
		end
		wr_reg(8'ha3, 8'h88);
		chk("unity", {unity_fb, npin_on}, 8'h10);
		@(posedge clock);
		conv_route <= 1'b1;
		conv_sel_valid <= 1'b1;
		conv_ppin <= 2'h2;
		conv_npin <= 2'h3;
		src(1'b0);
		chk("conv", {outpin_gpio_block, ppin_on}, 8'h14);
		wr_reg(8'ha3, 8'h80);
		chk("conv npin", npin_on, 8'h08);
		@(posedge clock);
		conv_route <= 1'b0;
		wr_reg(8'ha3, 8'h82);
		wr_reg(8'ha9, 8'h03);
		wr_reg(8'ha7, 8'hf0);
		src(1'b1);
		chk("high rail", {unity_fb, rail_high, rail_low}, 8'h02);
		wr_reg(8'ha7, 8'hcf);
		chk("inverted", {unity_fb, rail_high, rail_low}, 8'h01);
		wr_reg(8'ha9, 8'h16);
		src(1'b1);
		chk("reserved src", {unity_fb, rail_high, rail_low}, 8'h04);
		wr_reg(8'ha7, 8'h4f);
		chk("software", {unity_fb, rail_high, rail_low}, 8'h02);
		chk("short", short_err, 8'h00);
		end_sim();
	end
endmodule : amplifier_config_override_regs_tb
`default_nettype wire
